// *** intertrip_pkg.sv ***
// Package of constants for the DC pilot intertrip sequencer
package intertrip_pkg;
	localparam int CLK_HZ        = 100_000_000;
	localparam int TICK_NS       = 1_000_000;
	localparam int CLK_NS        = 10;
	localparam int TICK_CYC      = TICK_NS / CLK_NS;
	localparam int PULSE_MS      = 2000;
	localparam int RESET_MS      = 2000;
	localparam int DEBOUNCE_MS   = 10;
	localparam int FILTER_MS     = 11;
	localparam int RELAY_MS      = 7;
	localparam int TRIP_OUTS     = 4;
	localparam int MS_W          = 12;
	localparam int TICK_W        = 17;
endpackage

// *** ms_counter.sv ***
// Millisecond interval counter that counts timebase ticks
`timescale 1ns/1ns
module ms_counter #(
	parameter int W = 12
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         tick,
	input  wire logic         run,
	input  wire logic [W-1:0] limit,
	output logic              done
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic         done_nxt;

	always_comb begin
		cnt_nxt  = cnt_r;
		done_nxt = 1'b0;
		if (!run) begin
			cnt_nxt = '0;
		end else if (cnt_r >= limit) begin
			done_nxt = 1'b1;
		end else if (tick) begin
			cnt_nxt = cnt_r + 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
			done  <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			done  <= done_nxt & run;
		end
	end
endmodule

// *** dc_intertrip_sequencer.sv ***
// Intertrip send and receive sequencer for one pilot station
`timescale 1ns/1ns
module dc_intertrip_sequencer #(
	parameter int PULSE_MS    = intertrip_pkg::PULSE_MS,
	parameter int RESET_MS    = intertrip_pkg::RESET_MS,
	parameter int DEBOUNCE_MS = intertrip_pkg::DEBOUNCE_MS,
	parameter int FILTER_MS   = intertrip_pkg::FILTER_MS,
	parameter int RELAY_MS    = intertrip_pkg::RELAY_MS,
	parameter int TICK_CYC    = intertrip_pkg::TICK_CYC
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       initiate,
	input  wire logic       direct_link,
	input  wire logic       pilot_above_thr,
	input  wire logic       reset_button,
	input  wire logic       remote_reset,
	output logic            pilot_drive,
	output logic [3:0]      trip_out,
	output logic            send_ind,
	output logic            recv_ind,
	output logic            sup_suspend,
	output logic            busy
);
	localparam int MW = intertrip_pkg::MS_W;
	localparam int TW = intertrip_pkg::TICK_W;

	initial begin
		if (PULSE_MS < 1 || PULSE_MS >= (1 << MW) || RESET_MS >= (1 << MW) ||
		    TICK_CYC < 2 || TICK_CYC >= (1 << TW) || DEBOUNCE_MS < 1 || FILTER_MS < 1)
			$error("dc_intertrip_sequencer: unsupported parameter values");
	end

	typedef enum logic [1:0] {S_IDLE, S_SEND, S_SEND_HOLD, S_RECV} state_t;

	// Two-stage synchronisers on pin inputs
	logic [4:0] s1_r;
	logic [4:0] s2_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_r <= 5'h00;
			s2_r <= 5'h00;
		end else begin
			s1_r <= {remote_reset, reset_button, pilot_above_thr, direct_link, initiate};
			s2_r <= s1_r;
		end
	end
	logic init_s, link_s, thr_s, clr_s;
	assign init_s = s2_r[0];
	assign link_s = s2_r[1];
	assign thr_s  = s2_r[2];
	assign clr_s  = s2_r[3] | s2_r[4];

	// Millisecond timebase
	logic [TW-1:0] tick_cnt_r;
	logic [TW-1:0] tick_cnt_nxt;
	logic          tick_r;
	logic          tick_nxt;
	always_comb begin
		tick_nxt     = 1'b0;
		tick_cnt_nxt = tick_cnt_r + 1'b1;
		if (tick_cnt_r == TW'(TICK_CYC - 1)) begin
			tick_cnt_nxt = '0;
			tick_nxt     = 1'b1;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_cnt_r <= '0;
			tick_r     <= 1'b0;
		end else begin
			tick_cnt_r <= tick_cnt_nxt;
			tick_r     <= tick_nxt;
		end
	end

	// Interval timers
	state_t state_r, state_nxt;
	logic   db_done, flt_done, pulse_done, hold_done, rly_done, rcv_done;
	logic   flt_run, hold_run, rly_run, rcv_run;

	// Processor mode debounce; direct link bypasses it
	ms_counter #(.W(MW)) u_db (.clk(clk), .rst(rst), .tick(tick_r), .run(init_s),
		.limit(MW'(DEBOUNCE_MS)), .done(db_done));
	logic send_req;
	assign send_req = link_s ? init_s : db_done;

	// AC rejection qualification of pilot level
	assign flt_run = thr_s;
	ms_counter #(.W(MW)) u_flt (.clk(clk), .rst(rst), .tick(tick_r), .run(flt_run),
		.limit(MW'(FILTER_MS)), .done(flt_done));

	ms_counter #(.W(MW)) u_pulse (.clk(clk), .rst(rst), .tick(tick_r),
		.run(state_r == S_SEND), .limit(MW'(PULSE_MS)), .done(pulse_done));

	assign hold_run = (state_r == S_SEND_HOLD) && !init_s;
	ms_counter #(.W(MW)) u_hold (.clk(clk), .rst(rst), .tick(tick_r), .run(hold_run),
		.limit(MW'(RESET_MS)), .done(hold_done));

	assign rcv_run = (state_r == S_RECV) && !flt_done;
	ms_counter #(.W(MW)) u_rcv (.clk(clk), .rst(rst), .tick(tick_r), .run(rcv_run),
		.limit(MW'(RESET_MS)), .done(rcv_done));

	// Fixed relay actuation delay
	assign rly_run = (state_r == S_RECV);
	ms_counter #(.W(MW)) u_rly (.clk(clk), .rst(rst), .tick(tick_r), .run(rly_run),
		.limit(MW'(RELAY_MS)), .done(rly_done));

	// Sequencer
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			S_IDLE: begin
				if (send_req)
					state_nxt = S_SEND;
				else if (flt_done)
					state_nxt = S_RECV;
			end
			S_SEND: begin
				if (pulse_done)
					state_nxt = S_SEND_HOLD;
			end
			S_SEND_HOLD: begin
				if (hold_done)
					state_nxt = S_IDLE;
			end
			S_RECV: begin
				if (rcv_done)
					state_nxt = S_IDLE;
			end
			default: state_nxt = S_IDLE;
		endcase
	end

	// Output and indicator next values
	logic       drive_nxt, snd_nxt, rcv_nxt, sup_nxt, busy_nxt;
	logic [3:0] trip_nxt;
	always_comb begin
		drive_nxt = (state_nxt == S_SEND);
		trip_nxt  = {intertrip_pkg::TRIP_OUTS{(state_nxt == S_RECV) && rly_done}};
		busy_nxt  = (state_nxt != S_IDLE);
		sup_nxt   = busy_nxt;
		snd_nxt   = send_ind;
		rcv_nxt   = recv_ind;
		if (clr_s) begin
			snd_nxt = 1'b0;
			rcv_nxt = 1'b0;
		end
		if (state_nxt == S_SEND)
			snd_nxt = 1'b1;
		if (trip_nxt[0])
			rcv_nxt = 1'b1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r     <= S_IDLE;
			pilot_drive <= 1'b0;
			trip_out    <= 4'h0;
			send_ind    <= 1'b0;
			recv_ind    <= 1'b0;
			sup_suspend <= 1'b0;
			busy        <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			pilot_drive <= drive_nxt;
			trip_out    <= trip_nxt;
			send_ind    <= snd_nxt;
			recv_ind    <= rcv_nxt;
			sup_suspend <= sup_nxt;
			busy        <= busy_nxt;
		end
	end

	// Checks
	property p_no_self_trip;
		@(posedge clk) disable iff (rst) pilot_drive |-> trip_out == 4'h0;
	endproperty
	a_no_self_trip: assert property (p_no_self_trip) else $error("trip while sending");

	property p_sup_during_send;
		@(posedge clk) disable iff (rst) (pilot_drive || trip_out != 4'h0) |-> sup_suspend;
	endproperty
	a_sup_during_send: assert property (p_sup_during_send) else $error("supervision not held");

	property p_trips_parallel;
		@(posedge clk) disable iff (rst) trip_out == 4'h0 || trip_out == 4'hF;
	endproperty
	a_trips_parallel: assert property (p_trips_parallel) else $error("trip outputs split");

	property p_drive_start;
		@(posedge clk) disable iff (rst) $rose(pilot_drive) |-> send_ind;
	endproperty
	a_drive_start: assert property (p_drive_start) else $error("send indicator missing");

	property p_send_ignores_recv;
		@(posedge clk) disable iff (rst) pilot_drive |=> (trip_out == 4'h0);
	endproperty
	a_send_ignores_recv: assert property (p_send_ignores_recv) else $error("receipt while sending");

	property p_drive_holds;
		@(posedge clk) disable iff (rst) $rose(pilot_drive) |=> pilot_drive [*8];
	endproperty
	a_drive_holds: assert property (p_drive_holds) else $error("pulse cut short");

	property p_ind_latch;
		@(posedge clk) disable iff (rst) (recv_ind && !clr_s) |=> recv_ind;
	endproperty
	a_ind_latch: assert property (p_ind_latch) else $error("indicator lost");

	property p_busy_idle;
		@(posedge clk) disable iff (rst) !busy |-> (!pilot_drive && trip_out == 4'h0);
	endproperty
	a_busy_idle: assert property (p_busy_idle) else $error("activity while idle");
endmodule

// *** peer_station.sv ***
// Model of another station sharing the pilot
`timescale 1ns/1ns
module peer_station (
	input  wire logic clk,
	input  wire logic pilot_drive,
	input  wire logic peer_send,
	output logic      pilot_above_thr
);
	// Comparator sees own and peer pulses on the shared pilot
	always_ff @(posedge clk) pilot_above_thr <= pilot_drive | peer_send;
endmodule

// *** test_dc_intertrip_sequencer.sv ***
// Self-checking bench for the intertrip sequencer
`timescale 1ns/1ns
module test_dc_intertrip_sequencer;
	logic       clk, rst, initiate, direct_link, peer_send, reset_button, remote_reset;
	logic       pilot_above_thr, pilot_drive, send_ind, recv_ind, sup_suspend, busy;
	logic [3:0] trip_out;
	int         n_mismatch = 0;
	int         checked = 0;
	int         n;
	dc_intertrip_sequencer #(.PULSE_MS(20), .RESET_MS(20), .FILTER_MS(3),
		.RELAY_MS(2), .TICK_CYC(10)) u_dut (.clk, .rst, .initiate, .direct_link,
		.pilot_above_thr, .reset_button, .remote_reset, .pilot_drive, .trip_out,
		.send_ind, .recv_ind, .sup_suspend, .busy);
	peer_station u_peer (.clk, .pilot_drive, .peer_send, .pilot_above_thr);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(string name, logic [3:0] exp, logic [3:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Cycles until a watched output reaches val, capped at lim
	task automatic wait_for(int sel, logic val, int lim, output int k);
		logic s;
		k = 0;
		do begin
			@(posedge clk);
			#1;
			s = (sel == 0) ? pilot_drive : (sel == 1) ? trip_out[0] : busy;
			k++;
		end while (s !== val && k < lim);
	endtask
	task automatic in_win(string name, int lo, int hi);
		chk(name, 4'h1, {3'h0, n >= lo && n <= hi});
	endtask
	task automatic send_direct();
		@(posedge clk);
		direct_link <= 1'b1;
		initiate <= 1'b1;
		@(posedge clk);
		initiate <= 1'b0;
		wait_for(0, 1'b1, 20, n);
		in_win("direct_start", 1, 8);
		chk("suspend", 4'h1, {3'h0, sup_suspend});
		wait_for(0, 1'b0, 250, n);
		in_win("pulse_len", 190, 211);
		chk("own_trip", 4'h0, trip_out);
		wait_for(2, 1'b0, 250, n);
		in_win("hold_len", 190, 211);
		chk("suspend_end", 4'h0, {3'h0, sup_suspend});
		chk("send_ind", 4'h1, {3'h0, send_ind});
		@(posedge clk);
		reset_button <= 1'b1;
		@(posedge clk);
		reset_button <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk("send_clr", 4'h0, {3'h0, send_ind});
	endtask
	task automatic receive();
		@(posedge clk);
		direct_link <= 1'b0;
		peer_send <= 1'b1;
		wait_for(1, 1'b1, 100, n);
		in_win("recv_delay", 40, 75);
		chk("trip", 4'hF, trip_out);
		chk("suspend", 4'h1, {3'h0, sup_suspend});
		@(posedge clk);
		peer_send <= 1'b0;
		wait_for(1, 1'b0, 300, n);
		in_win("recv_hold", 190, 225);
		chk("recv_ind", 4'h1, {3'h0, recv_ind});
		@(posedge clk);
		remote_reset <= 1'b1;
		@(posedge clk);
		remote_reset <= 1'b0;
		peer_send <= 1'b1;
		repeat (10) @(posedge clk);
		peer_send <= 1'b0;
		repeat (150) @(posedge clk);
		#1;
		chk("glitch", 4'h0, {trip_out[2:0], recv_ind});
	endtask
	task automatic send_debounced();
		@(posedge clk);
		initiate <= 1'b1;
		@(posedge clk);
		initiate <= 1'b0;
		wait_for(0, 1'b1, 130, n);
		chk("short_init", 4'h0, {3'h0, pilot_drive});
		@(posedge clk);
		initiate <= 1'b1;
		wait_for(0, 1'b1, 130, n);
		in_win("debounce", 90, 115);
		@(posedge clk);
		peer_send <= 1'b1;
		repeat (50) @(posedge clk);
		peer_send <= 1'b0;
		wait_for(0, 1'b0, 250, n);
		repeat (250) @(posedge clk);
		#1;
		chk("sender_recv", 4'h0, {trip_out[2:0], recv_ind});
		chk("held_busy", 4'h1, {3'h0, busy});
		@(posedge clk);
		initiate <= 1'b0;
		wait_for(2, 1'b0, 250, n);
		in_win("release", 190, 225);
	endtask
	task automatic wrap_up();
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		wrap_up();
	end
	initial begin
		{rst, initiate, direct_link, peer_send, reset_button, remote_reset} = 6'h20;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		send_direct();
		receive();
		send_debounced();
		wrap_up();
	end
endmodule
